// >>> rtl/quad_dac_i2c_regs.v
// Two-wire slave, pointer, double-buffered DAC registers and power modes
`timescale 1ns/1ps
`default_nettype none
`include "qdac_map.vh"

module quad_dac_i2c_regs #(
  parameter DW = 12                          // DAC resolution, 8/10/12
) (
  input  wire        ref_clk,                // 25 MHz system clock
  input  wire        rst_n,                  // Async reset, active low
  input  wire        scl_in,                 // Serial clock pin level
  input  wire        sda_in,                 // Serial data pin level
  output reg         sda_out,                // Data drive value, always 0
  output reg         sda_oe,                 // High while pulling data low
  input  wire        address_select_pin,     // Address lsb strap
  output reg  [47:0] dac_code,               // Four 12-bit DAC registers
  output reg  [7:0]  power_mode,             // Two mode bits per channel
  output reg  [3:0]  out_enable,             // Amplifier drives output
  output reg  [3:0]  out_pull_1k,            // 1k path to ground
  output reg  [3:0]  out_pull_100k,          // 100k path to ground
  output reg  [3:0]  out_tristate            // Output left open
);

  // ---------------------------------------------------------------
  // States, one-hot
  // ---------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01;           // Not addressed
  localparam [5:0] S_ADDR = 6'h02;           // Receiving address
  localparam [5:0] S_RX   = 6'h04;           // Receiving write bytes
  localparam [5:0] S_ACK  = 6'h08;           // Our acknowledge slot
  localparam [5:0] S_TX   = 6'h10;           // Sending read byte
  localparam [5:0] S_MACK = 6'h20;           // Master acknowledge slot

  // Keeps only the top DW bits of the left-justified code
  localparam [11:0] CODE_MASK = 12'hfff << (12 - DW);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // True when exactly one channel select bit is set
  function one_sel;
    input [3:0] s;
    begin
      one_sel = (s == 4'h1) || (s == 4'h2) || (s == 4'h4) || (s == 4'h8);
    end
  endfunction

  // Output stage controls for a mode code: {en, 1k, 100k, tri}
  function [3:0] mode_dec;
    input [1:0] m;
    begin
      case (m)
        `QDAC_MODE_NORMAL:  mode_dec = 4'h8;
        `QDAC_MODE_PD_1K:   mode_dec = 4'h4;
        `QDAC_MODE_PD_100K: mode_dec = 4'h2;
        `QDAC_MODE_PD_TRI:  mode_dec = 4'h1;
        default:            mode_dec = 4'h1;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers, three stages
  // ---------------------------------------------------------------
  reg  [2:0] scl_sy_q;                       // Clock pin stages
  reg  [2:0] sda_sy_q;                       // Data pin stages
  reg  [2:0] strap_sy_q;                     // Strap stages
  reg        scl_q;                          // Accepted clock level
  reg        sda_q;                          // Accepted data level
  reg        strap_q;                        // Accepted strap level

  // First stage feeds only the second; change taken when 2 and 3 agree
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      strap_sy_q <= 3'h0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      strap_q  <= 1'b0;
    end
    else
    begin
      scl_sy_q <= {scl_sy_q[1:0], scl_in};
      sda_sy_q <= {sda_sy_q[1:0], sda_in};
      strap_sy_q <= {strap_sy_q[1:0], address_select_pin};
      if (scl_sy_q[1] == scl_sy_q[2])
        scl_q <= scl_sy_q[2];
      if (sda_sy_q[1] == sda_sy_q[2])
        sda_q <= sda_sy_q[2];
      if (strap_sy_q[1] == strap_sy_q[2])
        strap_q <= strap_sy_q[2];
    end
  end

  // Edge and condition decode on accepted levels
  wire scl_nx  = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_q;
  wire sda_nx  = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_q;
  wire scl_ris = !scl_q && scl_nx;           // Clock rising
  wire scl_fal = scl_q && !scl_nx;           // Clock falling
  wire start_c = scl_q && scl_nx && sda_q && !sda_nx;
  wire stop_c  = scl_q && scl_nx && !sda_q && sda_nx;

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  reg  [5:0]  st_q;                          // Slave state
  reg  [2:0]  cnt_q;                         // Bit within byte
  reg         done_q;                        // Eighth bit taken
  reg         match_q;                       // Address matched
  reg         rd_q;                          // Read direction
  reg  [1:0]  bidx_q;                        // Write byte index
  reg  [6:0]  rx_q;                          // Receive shifter
  reg  [7:0]  tx_q;                          // Transmit shifter
  reg         rbyte_q;                       // Read byte select
  reg         macked_q;                      // Master acknowledged
  reg  [7:0]  ptr_q;                         // Pointer byte
  reg  [7:0]  hi_q;                          // First data byte
  reg         commit_q;                      // Word complete pulse
  reg  [15:0] word_q;                        // Completed data word

  wire [7:0] rx_byte = {rx_q, sda_nx};       // Byte at eighth rise
  wire [3:0] sel     = ptr_q[`QDAC_PTR_SEL_MSB:0];

  // Channel registers, declared per channel below
  wire [11:0] in_w  [0:3];
  wire [1:0]  ctl_w [0:3];
  wire [1:0]  md_w  [0:3];
  wire [11:0] dac_w [0:3];                   // DAC register per channel

  // Readback word for the current pointer
  reg  [15:0] rb_word;
  integer k;

  // Single selection shows that channel, otherwise the default
  always @*
  begin
    rb_word = `QDAC_RB_DEFAULT;
    for (k = 0; k < 4; k = k + 1)
      if (one_sel(sel) && sel[k])
        rb_word = {md_w[k], ctl_w[k], in_w[k]};
  end

  // Slave sequencer, acts on clock edges and bus conditions
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= S_IDLE;
      cnt_q    <= 3'h0;
      done_q   <= 1'b0;
      match_q  <= 1'b0;
      rd_q     <= 1'b0;
      bidx_q   <= 2'h0;
      rx_q     <= 7'h00;
      tx_q     <= 8'h00;
      rbyte_q  <= 1'b0;
      macked_q <= 1'b0;
      ptr_q    <= `QDAC_PTR_RESET;
      hi_q     <= 8'h00;
      commit_q <= 1'b0;
      word_q   <= 16'h0000;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
    end
    else
    begin
      commit_q <= 1'b0;
      if (stop_c)
      begin
        // Stop ends any transfer and frees the line
        st_q   <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
        // Start or repeated start, address follows
        st_q   <= S_ADDR;
        cnt_q  <= 3'h0;
        done_q <= 1'b0;
        bidx_q <= 2'h0;
        sda_oe <= 1'b0;
      end
      else if (scl_ris)
      begin
        case (st_q)
          S_ADDR, S_RX:
          begin
            rx_q  <= rx_byte[6:0];
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
              done_q <= 1'b1;
              if (st_q == S_ADDR)
              begin
                match_q <= (rx_byte[7:1] == {`QDAC_ADDR_HI, strap_q});
                rd_q    <= rx_byte[0];
              end
              else
              begin
                bidx_q <= (bidx_q == 2'h3) ? bidx_q : bidx_q + 2'h1;
                if (bidx_q == 2'h0)
                  ptr_q <= rx_byte;
                else if (bidx_q == 2'h1)
                  hi_q <= rx_byte;
                else if (bidx_q == 2'h2)
                begin
                  // Eighth rise of the low byte applies the word
                  word_q   <= {hi_q, rx_byte};
                  commit_q <= 1'b1;
                end
              end
            end
          end
          S_TX:
          begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
              done_q <= 1'b1;
          end
          S_MACK:
            macked_q <= !sda_nx;
          default:
            cnt_q <= cnt_q;
        endcase
      end
      else if (scl_fal)
      begin
        case (st_q)
          S_ADDR, S_RX:
            if (done_q)
            begin
              done_q <= 1'b0;
              cnt_q  <= 3'h0;
              if (st_q == S_ADDR && !match_q)
                st_q <= S_IDLE;
              else
              begin
                sda_oe <= 1'b1;
                st_q   <= S_ACK;
              end
            end
          S_ACK:
            if (rd_q)
            begin
              // Read starts with the high byte of the pointer target
              tx_q    <= {rb_word[14:8], 1'b0};
              sda_oe  <= !rb_word[15];
              rbyte_q <= 1'b0;
              st_q    <= S_TX;
            end
            else
            begin
              sda_oe <= 1'b0;
              st_q   <= S_RX;
            end
          S_TX:
            if (done_q)
            begin
              done_q <= 1'b0;
              cnt_q  <= 3'h0;
              sda_oe <= 1'b0;
              st_q   <= S_MACK;
            end
            else
            begin
              tx_q   <= {tx_q[6:0], 1'b0};
              sda_oe <= !tx_q[7];
            end
          S_MACK:
            if (macked_q)
            begin
              // Alternate bytes endlessly while acknowledged
              rbyte_q <= !rbyte_q;
              if (rbyte_q)
              begin
                tx_q   <= {rb_word[14:8], 1'b0};
                sda_oe <= !rb_word[15];
              end
              else
              begin
                tx_q   <= {rb_word[6:0], 1'b0};
                sda_oe <= !rb_word[7];
              end
              st_q <= S_TX;
            end
            else
              st_q <= S_IDLE;
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-channel double-buffered registers
  // ---------------------------------------------------------------
  wire w_clear_n = word_q[`QDAC_W_CLEAR_N];
  wire w_load_n = word_q[`QDAC_W_LOAD_N];
  wire [11:0] w_code = word_q[`QDAC_CODE_MSB:0] & CODE_MASK;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : ch
      reg [11:0] in_q;                       // Input register
      reg [11:0] dac_q;                      // DAC register
      reg        dirty_q;                    // Input newer than DAC
      reg [1:0]  ctl_q;                      // Last clear/load bits
      reg [1:0]  md_q;                       // Power mode
      wire       hit = sel[g];               // Channel addressed

      assign in_w[g]  = in_q;
      assign ctl_w[g] = ctl_q;
      assign md_w[g]  = md_q;
      assign dac_w[g] = dac_q;

      // Word commit; clear beats load, load beats hold
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          in_q    <= 12'h000;
          dac_q   <= 12'h000;
          dirty_q <= 1'b0;
          ctl_q   <= 2'h2;
          md_q    <= `QDAC_MODE_NORMAL;
        end
        else if (commit_q)
        begin
          if (hit)
          begin
            ctl_q <= {w_clear_n, w_load_n};
            md_q  <= word_q[`QDAC_W_MODE_MSB:`QDAC_W_MODE_LSB];
          end
          if (!w_clear_n)
          begin
            in_q    <= 12'h000;
            dac_q   <= 12'h000;
            dirty_q <= 1'b0;
          end
          else if (!w_load_n)
          begin
            // Skip untouched channels to save needless updates
            if (hit)
              in_q <= w_code;
            if (hit)
              dac_q <= w_code;
            else if (dirty_q)
              dac_q <= in_q;
            dirty_q <= 1'b0;
          end
          else if (hit)
          begin
            in_q    <= w_code;
            dirty_q <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  integer j;                                 // Channel loop index

  // One process owns every output vector, so no bit has two drivers;
  // mode never disturbs the code held
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_code      <= 48'h000000000000;
      power_mode    <= 8'h00;
      out_enable    <= 4'hf;
      out_pull_1k   <= 4'h0;
      out_pull_100k <= 4'h0;
      out_tristate  <= 4'h0;
    end
    else
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        dac_code[j*12 +: 12] <= dac_w[j];
        power_mode[j*2 +: 2] <= md_w[j];
        out_enable[j]        <= mode_dec(md_w[j]) == 4'h8;
        out_pull_1k[j]       <= mode_dec(md_w[j]) == 4'h4;
        out_pull_100k[j]     <= mode_dec(md_w[j]) == 4'h2;
        out_tristate[j]      <= mode_dec(md_w[j]) == 4'h1;
      end
    end
  end

endmodule // quad_dac_i2c_regs
`default_nettype wire

// >>> rtl/qdac_map.vh
// Constants for the quad DAC two-wire slave and register logic
// Notes on behaviour
// - Pointer byte clears to zero at power-on
// - No channel selected: readback zero, clear bit one
// - Multi-select write applies word to all selected
// - Multi-select readback returns power-on default pattern
// - Acknowledge matching address and pointer byte
// - Pointer write, repeated start, read two bytes
// - Master ack keeps the two bytes repeating
// - Address-only read uses stored pointer settings
// - Readback layout equals write, don't-cares zero
// - Completed write loads selected input registers
// - Load bit high holds DAC registers
// - Load bit low transfers inputs to DACs
// - Transfer only channels written since last update
// - Power mode from word bits 15 and 14
// - Modes: normal, 1k, 100k, three-state
// - DAC registers kept during power-down
// - Power-down exit from eighth clock rise
// - Address 000110 plus select pin level
// - Word: mode, clear_n, load_n, left-justified code
// - Clear bit low zeroes input and DAC registers
`ifndef QDAC_MAP_VH
`define QDAC_MAP_VH
`define QDAC_ADDR_HI      6'b000110
`define QDAC_PTR_SEL_MSB  3
`define QDAC_PTR_RESET    8'h00
`define QDAC_W_MODE_MSB   15
`define QDAC_W_MODE_LSB   14
`define QDAC_W_CLEAR_N    13
`define QDAC_W_LOAD_N     12
`define QDAC_CODE_MSB     11
`define QDAC_RB_DEFAULT   16'h2000
`define QDAC_MODE_NORMAL  2'h0
`define QDAC_MODE_PD_1K   2'h1
`define QDAC_MODE_PD_100K 2'h2
`define QDAC_MODE_PD_TRI  2'h3
`endif

// >>> dv/i2c_master_model.sv
// Two-wire bus master model: drives the serial clock and pulls data low
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic ref_clk,  // Paces the bus, changes at falling edge
  output var  logic scl,      // Serial clock, stands high between frames
  output var  logic sda_low,  // High while pulling data low
  input  wire logic sda_line  // Resolved data wire, pulled up
);
  // --------------------------------------
  // Bus timing: one quarter bit = 80 ns
  // --------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qwait(input int n);
    repeat (2 * n) @(negedge ref_clk);
  endtask
  // Data changes mid-low, read at the end of high
  task automatic bit_io(input logic b, output logic got);
    qwait(1);
    sda_low = !b;
    qwait(1);
    scl = 1'b1;
    qwait(2);
    got = sda_line;
    scl = 1'b0;
  endtask
  // Start, or repeated start when the clock is parked low
  task automatic start;
    if (!scl)
    begin
      qwait(1);
      sda_low = 1'b0;
      qwait(1);
      scl = 1'b1;
      qwait(2);
    end
    sda_low = 1'b1;
    qwait(2);
    scl = 1'b0;
  endtask
  // Eight bits then the ninth slot; sending 8'hff lets the slave talk
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
  // Stop; data released so the pull-up takes the line
  task automatic stop;
    qwait(1);
    sda_low = 1'b1;
    qwait(1);
    scl = 1'b1;
    qwait(2);
    sda_low = 1'b0;
    qwait(2);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// >>> dv/qdac_props.sv
// Port-level assertions for the quad DAC two-wire slave
`timescale 1ns/1ps
`default_nettype none
module qdac_props #(
  parameter int DW = 12  // DAC resolution
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        address_select_pin,
  input wire logic [47:0] dac_code,
  input wire logic [7:0]  power_mode,
  input wire logic [3:0]  out_enable,
  input wire logic [3:0]  out_pull_1k,
  input wire logic [3:0]  out_pull_100k,
  input wire logic [3:0]  out_tristate
);
  // ---------
  // Helpers
  // ---------
  logic       scl_q;       // Pin level one clock ago
  logic [3:0] rise_age_q;  // Clocks since last rise, saturating
  logic [3:0] rise_age_d;  // Next count
  // Restart on every rise so commits can be tied to it
  always_comb
  begin
    rise_age_d = (rise_age_q == 4'hf) ? 4'hf : rise_age_q + 4'h1;
    if (scl_in && !scl_q)
      rise_age_d = 4'h0;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q      <= 1'b1;
      rise_age_q <= 4'hf;
    end
    else
    begin
      scl_q      <= scl_in;
      rise_age_q <= rise_age_d;
    end
  end
  // Channels whose mode field equals m
  function automatic logic [3:0] chans(input logic [7:0] pm, input logic [1:0] m);
    for (int i = 0; i < 4; i++)
      chans[i] = pm[2*i +: 2] == m;
  endfunction
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence mode_settled;
    $stable(power_mode) ##1 $stable(power_mode);
  endsequence
  sequence bus_idle;
    scl_in [*8];
  endsequence
  a_normal_drives:
    assert property (mode_settled |-> out_enable == chans(power_mode, 2'h0))
    else $error("enable does not follow normal mode");
  a_pull_low_ohm:
    assert property (mode_settled |-> out_pull_1k == chans(power_mode, 2'h1))
    else $error("1k path does not follow mode");
  a_pull_high_ohm:
    assert property (mode_settled |-> out_pull_100k == chans(power_mode, 2'h2))
    else $error("100k path does not follow mode");
  a_open_output:
    assert property (mode_settled |-> out_tristate == chans(power_mode, 2'h3))
    else $error("three-state does not follow mode");
  a_sda_pull_only:
    assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_reset_state:
    assert property ($rose(rst_n) |-> dac_code == 48'h0 && power_mode == 8'h0 && !sda_oe)
    else $error("state not cleared by reset");
  a_oe_after_fall:
    assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("data drive began while clock high");
  a_idle_release:
    assert property (bus_idle |-> !sda_oe)
    else $error("data held low on idle bus");
  a_commit_on_rise:
    assert property (($changed(dac_code) || $changed(power_mode)) |-> rise_age_q inside {[2:7]})
    else $error("registers changed away from a clock rise");
endmodule // qdac_props
bind quad_dac_i2c_regs qdac_props #(.DW(DW)) u_qdac_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .address_select_pin(address_select_pin), .dac_code(dac_code), .power_mode(power_mode),
  .out_enable(out_enable), .out_pull_1k(out_pull_1k), .out_pull_100k(out_pull_100k), .out_tristate(out_tristate)
);
`default_nettype wire

// >>> dv/quad_dac_i2c_register_interface_bench.sv
// Self-checking bench: writes, readbacks and resets through the bus model
`timescale 1ns/1ps
`default_nettype none
`include "qdac_map.vh"
module quad_dac_i2c_register_interface_bench;
  // ---------
  // Signals
  // ---------
  logic        ref_clk;      // 25 MHz clock
  logic        rst_n;        // Async reset, active low
  logic        scl;          // Bus clock from the model
  logic        mst_low;      // Model pulls data low
  logic        sda_line;     // Resolved wire, pull-up
  logic        sda_out;
  logic        sda_oe;
  logic        a_sel;        // Address strap
  logic [47:0] dac_code;
  logic [7:0]  power_mode;
  int          failures;
  int          check_count;
  int          cycles;
  typedef struct packed {logic [7:0] ptr; logic [15:0] word; logic [47:0] dac; logic [7:0] mode; logic [15:0] rb;} row_t;
  // Reserved pointer bits always zero
  row_t rows [8] = '{
    '{8'h01, 16'h2abc, 48'h000000000abc, 8'h00, 16'h2abc},
    '{8'h0e, 16'h3123, 48'h000000000abc, 8'h00, 16'h2000},
    '{8'h02, 16'h2456, 48'h123123456abc, 8'h00, 16'h2456},
    '{8'h08, 16'h7fff, 48'h123123456abc, 8'h40, 16'h7fff},
    '{8'h04, 16'hb000, 48'h123123456abc, 8'h60, 16'hb000},
    '{8'h01, 16'he000, 48'hfff000456000, 8'h63, 16'he000},
    '{8'h0f, 16'h0000, 48'h000000000000, 8'h00, 16'h2000},
    '{8'h00, 16'h2111, 48'h000000000000, 8'h00, 16'h2000}};
  // Open-drain wire: low if either party pulls
  assign sda_line = (mst_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  i2c_master_model mst (.ref_clk(ref_clk), .scl(scl), .sda_low(mst_low), .sda_line(sda_line));
  quad_dac_i2c_regs #(.DW(12)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(a_sel), .dac_code(dac_code), .power_mode(power_mode),
    .out_enable(), .out_pull_1k(), .out_pull_100k(), .out_tristate());
  // ---------------
  // Checks, tasks
  // ---------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One byte out, then compare the ninth slot
  task automatic send(input logic [7:0] b, input logic nack);
    logic [7:0] rx;
    logic       a;
    mst.byte_io(b, 1'b1, rx, a);
    check(a, nack);
  endtask
  task automatic write_word(input logic [7:0] ptr, input logic [15:0] w);
    mst.start();
    send({`QDAC_ADDR_HI, a_sel, 1'b0}, 1'b0);
    send(ptr, 1'b0);
    send(w[15:8], 1'b0);
    send(w[7:0], 1'b0);
    mst.stop();
  endtask
  // Word read twice: master acks the first pair, nacks the last byte
  task automatic read_back(input logic set_ptr, input logic [7:0] ptr, input logic [15:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       a;
    mst.start();
    if (set_ptr)
    begin
      send({`QDAC_ADDR_HI, a_sel, 1'b0}, 1'b0);
      send(ptr, 1'b0);
      mst.start();
    end
    send({`QDAC_ADDR_HI, a_sel, 1'b1}, 1'b0);
    for (int n = 0; n < 2; n++)
    begin
      mst.byte_io(8'hff, 1'b0, hi, a);
      mst.byte_io(8'hff, n == 1, lo, a);
      check({hi, lo}, exp);
    end
    mst.stop();
  endtask
  // ----------------
  // Clock, watchdog
  // ----------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Whole run needs about 8k cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      $display("unexpected at %0t ns: run too long", $time);
      wrap_up();
    end
  end
  // -----------
  // Sequence
  // -----------
  initial
  begin
    rst_n = 1'b0;
    a_sel = 1'b0;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    foreach (rows[i])
    begin
      write_word(rows[i].ptr, rows[i].word);
      check(dac_code, rows[i].dac);
      check(power_mode, rows[i].mode);
      read_back(1'b1, rows[i].ptr, rows[i].rb);
    end
    // Address-only read reuses the stored pointer
    write_word(8'h02, 16'h2789);
    check(dac_code, 48'h000000789000);
    read_back(1'b0, 8'h00, 16'h2789);
    // Reset in mid-run clears codes and the pointer
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(dac_code, 48'h0);
    read_back(1'b0, 8'h00, `QDAC_RB_DEFAULT);
    // Strap high: own address acked, the other refused
    a_sel = 1'b1;
    repeat (8) @(negedge ref_clk);
    write_word(8'h01, 16'h2fed);
    check(dac_code, 48'h000000000fed);
    mst.start();
    send({`QDAC_ADDR_HI, 1'b0, 1'b0}, 1'b1);
    mst.stop();
    wrap_up();
  end
endmodule // quad_dac_i2c_register_interface_bench
`default_nettype wire
